// File: pkg/cht_pkg.sv
// Constants, types and field layouts of the charger telemetry word bank.
// Assumes one clock domain shared with the measurement engine and the serial register port.
package cht_pkg;

    // ************************************************************
    // Word map
    // ************************************************************
    localparam int CHT_WORDS = 9;
    localparam int CHT_IDX_W = 4;
    localparam int CHT_DATA_W = 16;
    localparam logic [7:0] CHT_OFF_BATTERY_TEMPERATURE = 8'h00;
    localparam logic [7:0] CHT_OFF_OUTPUT_POWER = 8'h02;
    localparam logic [7:0] CHT_OFF_INPUT_POWER = 8'h04;
    localparam logic [7:0] CHT_OFF_CONVERSION_EFFICIENCY = 8'h06;
    localparam logic [7:0] CHT_OFF_OUTPUT_CURRENT = 8'h08;
    localparam logic [7:0] CHT_OFF_INPUT_CURRENT = 8'h0A;
    localparam logic [7:0] CHT_OFF_BATTERY_VOLTAGE = 8'h0C;
    localparam logic [7:0] CHT_OFF_INPUT_VOLTAGE_FEEDBACK = 8'h0E;
    localparam logic [7:0] CHT_OFF_INPUT_VOLTAGE_PANEL = 8'h10;
    localparam logic [3:0] CHT_IX_TEMP = 4'h0;
    localparam logic [3:0] CHT_IX_POUT = 4'h1;
    localparam logic [3:0] CHT_IX_PIN = 4'h2;
    localparam logic [3:0] CHT_IX_EFF = 4'h3;
    localparam logic [3:0] CHT_IX_IOUT = 4'h4;
    localparam logic [3:0] CHT_IX_IIN = 4'h5;
    localparam logic [3:0] CHT_IX_VBAT = 4'h6;
    localparam logic [3:0] CHT_IX_VFB = 4'h7;
    localparam logic [3:0] CHT_IX_VPANEL = 4'h8;
    localparam logic [3:0] CHT_IX_LAST = 4'h8;

    // ************************************************************
    // Reset values and special codes
    // ************************************************************
    localparam logic [15:0] CHT_RST_TEMP = 16'h7FFF;
    localparam logic [15:0] CHT_RST_VPANEL = 16'hFFFF;
    localparam logic [15:0] CHT_RST_ZERO = 16'h0000;
    localparam logic [15:0] CHT_TEMP_DISCONNECT = 16'h7777;
    localparam logic [15:0] CHT_CFG_INVALID = 16'hFFFF;
    localparam logic [15:0] CHT_CFG_ZERO = 16'h0000;
    localparam logic [15:0] CHT_PWR_SAT = 16'hFFFE;
    localparam logic signed [15:0] CHT_TEMP_MIN = 16'shFE3E;
    localparam logic signed [15:0] CHT_TEMP_MAX = 16'sh028A;
    localparam logic [15:0] CHT_EFF_MAX = 16'h270F;
    localparam logic [31:0] CHT_POWER_DIV = 32'h0000_03E8;
    localparam logic [31:0] CHT_EFF_SCALE = 32'h0000_2710;
    localparam logic [143:0] CHT_RESET_IMAGE = {CHT_RST_VPANEL, {7{CHT_RST_ZERO}}, CHT_RST_TEMP};
    localparam int CHT_READ_LATENCY = 2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        CHT_IDLE = 2'b00,
        CHT_POWER = 2'b01,
        CHT_EFF = 2'b11,
        CHT_WRITE = 2'b10
    } cht_state_t;

    typedef struct packed {
        logic tbat_valid;
        logic batt_disconnected;
        logic [15:0] tbat_c10;
        logic iout_valid;
        logic [15:0] iout_ma;
        logic iin_valid;
        logic [15:0] iin_ma;
        logic vbat_valid;
        logic [15:0] vbat_v100;
        logic vfb_valid;
        logic [15:0] vfb_v100;
        logic vpanel_valid;
        logic [15:0] vpanel_v100;
        logic dc_supply;
    } cht_meas_t;

    typedef struct packed {
        logic [15:0] input_sense_resistor_setting;
        logic [15:0] output_sense_resistor_setting;
        logic [15:0] output_monitor_resistor_setting;
        logic [15:0] output_dac_resistor_setting;
        logic [15:0] output_divider_upper_setting;
        logic [15:0] output_divider_lower_setting;
        logic [15:0] input_dac_resistor_setting;
        logic [15:0] input_divider_upper_setting;
        logic [15:0] input_divider_lower_setting;
    } cht_cfg_t;

endpackage

// File: hdl/cht_word_mem.sv
// Small word store holding the host-visible telemetry words.
// Assumes a single writer and a single reader on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cht_word_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 9,
    parameter int IDX_W = 4,
    parameter logic [WIDTH*DEPTH-1:0] RESET_IMAGE = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Write port
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    // Read port
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] word_reg [DEPTH];

    // Read-before-write: a read in the cycle of a write sees the old whole word.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_data <= '0;
        end
        else if (int'(rd_idx) < DEPTH)
        begin
            rd_data <= word_reg[rd_idx];
        end
        else
        begin
            rd_data <= '0;
        end
    end

    generate
        for (genvar i = 0; i < DEPTH; i++)
        begin : g_word
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    word_reg[i] <= RESET_IMAGE[i*WIDTH +: WIDTH];
                end
                else if (wr_en && (int'(wr_idx) == i))
                begin
                    word_reg[i] <= wr_data;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// File: hdl/cht_telemetry_bank.sv
// Telemetry word bank of a battery charge controller, read by the serial register port.
// Assumes measurement strobes, settings and the port request come from logic on CLK.
`timescale 1ns/1ps
`default_nettype none
module cht_telemetry_bank (
    // Clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // Measurement engine and settings
    input wire cht_pkg::cht_meas_t MEAS,
    input wire cht_pkg::cht_cfg_t CFG,
    // Register read port
    input wire logic RD_REQ,
    input wire logic [7:0] RD_ADDR,
    output logic [15:0] RD_DATA,
    output logic RD_VALID,
    output logic RD_ERR
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a[0] == 1'b0) && (a <= cht_pkg::CHT_OFF_INPUT_VOLTAGE_PANEL);
    endfunction

    function automatic logic [15:0] scale_power(input logic [31:0] prod);
        logic [31:0] q;
        q = prod / cht_pkg::CHT_POWER_DIV;
        if (q > {16'h0000, cht_pkg::CHT_PWR_SAT})
        begin
            scale_power = cht_pkg::CHT_PWR_SAT;
        end
        else
        begin
            scale_power = q[15:0];
        end
    endfunction

    function automatic logic [15:0] clamp_temp(input logic signed [15:0] t);
        if (t < cht_pkg::CHT_TEMP_MIN)
        begin
            clamp_temp = cht_pkg::CHT_TEMP_MIN;
        end
        else if (t > cht_pkg::CHT_TEMP_MAX)
        begin
            clamp_temp = cht_pkg::CHT_TEMP_MAX;
        end
        else
        begin
            clamp_temp = t;
        end
    endfunction

    // ************************************************************
    // Latest values
    // ************************************************************
    logic [15:0] temp_reg;
    logic [15:0] pout_reg;
    logic [15:0] pin_reg;
    logic [15:0] eff_reg;
    logic [15:0] iout_reg;
    logic [15:0] iin_reg;
    logic [15:0] vbat_reg;
    logic [15:0] vfb_reg;
    logic [15:0] vpanel_reg;
    logic temp_seen_reg;
    cht_pkg::cht_state_t state_reg;
    cht_pkg::cht_state_t state_next;
    logic [3:0] idx_reg;
    logic pending_reg;
    logic any_valid;

    assign any_valid = MEAS.tbat_valid | MEAS.iout_valid | MEAS.iin_valid | MEAS.vbat_valid
        | MEAS.vfb_valid | MEAS.vpanel_valid;

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            temp_reg <= cht_pkg::CHT_RST_TEMP;
            temp_seen_reg <= 1'b0;
        end
        else if (MEAS.tbat_valid)
        begin
            temp_seen_reg <= 1'b1;
            if (MEAS.batt_disconnected)
            begin
                temp_reg <= cht_pkg::CHT_TEMP_DISCONNECT;
            end
            else
            begin
                temp_reg <= clamp_temp(MEAS.tbat_c10);
            end
        end
    end

    // Currents and voltages are stored as delivered in their own units.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            iout_reg <= cht_pkg::CHT_RST_ZERO;
            iin_reg <= cht_pkg::CHT_RST_ZERO;
            vbat_reg <= cht_pkg::CHT_RST_ZERO;
            vfb_reg <= cht_pkg::CHT_RST_ZERO;
        end
        else
        begin
            if (MEAS.iout_valid)
            begin
                iout_reg <= MEAS.iout_ma;
            end
            if (MEAS.iin_valid)
            begin
                iin_reg <= MEAS.iin_ma;
            end
            if (MEAS.vbat_valid)
            begin
                vbat_reg <= MEAS.vbat_v100;
            end
            if (MEAS.vfb_valid)
            begin
                vfb_reg <= MEAS.vfb_v100;
            end
        end
    end

    // The panel pin is pulled low on DC supply, so its reading is meaningless then.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            vpanel_reg <= cht_pkg::CHT_RST_VPANEL;
        end
        else if (MEAS.dc_supply)
        begin
            vpanel_reg <= cht_pkg::CHT_RST_ZERO;
        end
        else if (MEAS.vpanel_valid)
        begin
            vpanel_reg <= MEAS.vpanel_v100;
        end
    end

    // ************************************************************
    // Derived words
    // ************************************************************
    logic out_cfg_zero;
    logic in_cfg_zero;
    logic [15:0] vin_sel;
    logic [15:0] pout_calc;
    logic [15:0] pin_calc;
    logic [15:0] eff_calc;
    logic [31:0] eff_q;

    assign out_cfg_zero = (CFG.output_sense_resistor_setting == cht_pkg::CHT_CFG_ZERO)
        || (CFG.output_monitor_resistor_setting == cht_pkg::CHT_CFG_ZERO)
        || (CFG.output_dac_resistor_setting == cht_pkg::CHT_CFG_ZERO)
        || (CFG.output_divider_upper_setting == cht_pkg::CHT_CFG_ZERO)
        || (CFG.output_divider_lower_setting == cht_pkg::CHT_CFG_ZERO);
    assign in_cfg_zero = (CFG.input_sense_resistor_setting == cht_pkg::CHT_CFG_ZERO)
        || (MEAS.dc_supply && ((CFG.input_dac_resistor_setting == cht_pkg::CHT_CFG_ZERO)
        || (CFG.input_divider_upper_setting == cht_pkg::CHT_CFG_ZERO)
        || (CFG.input_divider_lower_setting == cht_pkg::CHT_CFG_ZERO)));
    assign vin_sel = MEAS.dc_supply ? vfb_reg : vpanel_reg;
    assign pout_calc = out_cfg_zero ? cht_pkg::CHT_CFG_INVALID
        : scale_power(32'(iout_reg) * 32'(vbat_reg));
    assign pin_calc = in_cfg_zero ? cht_pkg::CHT_CFG_INVALID
        : scale_power(32'(iin_reg) * 32'(vin_sel));
    assign eff_q = (pin_reg == cht_pkg::CHT_RST_ZERO) ? 32'h0000_0000
        : (32'(pout_reg) * cht_pkg::CHT_EFF_SCALE) / 32'(pin_reg);

    always_comb
    begin
        if ((pout_reg == cht_pkg::CHT_CFG_INVALID) || (pin_reg == cht_pkg::CHT_CFG_INVALID))
        begin
            eff_calc = cht_pkg::CHT_CFG_INVALID;
        end
        else if (eff_q > {16'h0000, cht_pkg::CHT_EFF_MAX})
        begin
            eff_calc = cht_pkg::CHT_EFF_MAX;
        end
        else
        begin
            eff_calc = eff_q[15:0];
        end
    end

    // ************************************************************
    // Update sequencer
    // ************************************************************
    always_comb
    begin
        case (state_reg)
            cht_pkg::CHT_IDLE: state_next = pending_reg ? cht_pkg::CHT_POWER : cht_pkg::CHT_IDLE;
            cht_pkg::CHT_POWER: state_next = cht_pkg::CHT_EFF;
            cht_pkg::CHT_EFF: state_next = cht_pkg::CHT_WRITE;
            cht_pkg::CHT_WRITE: state_next = (idx_reg == cht_pkg::CHT_IX_LAST)
                ? cht_pkg::CHT_IDLE : cht_pkg::CHT_WRITE;
            default: state_next = cht_pkg::CHT_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            state_reg <= cht_pkg::CHT_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // A new sample arriving while the sequencer starts is kept: set beats clear.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pending_reg <= 1'b0;
        end
        else
        begin
            pending_reg <= any_valid | (pending_reg & (state_reg != cht_pkg::CHT_IDLE));
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            idx_reg <= cht_pkg::CHT_IX_TEMP;
        end
        else if (state_reg == cht_pkg::CHT_WRITE)
        begin
            idx_reg <= (idx_reg == cht_pkg::CHT_IX_LAST) ? cht_pkg::CHT_IX_TEMP : idx_reg + 4'h1;
        end
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            pout_reg <= cht_pkg::CHT_RST_ZERO;
            pin_reg <= cht_pkg::CHT_RST_ZERO;
            eff_reg <= cht_pkg::CHT_RST_ZERO;
        end
        else if (state_reg == cht_pkg::CHT_POWER)
        begin
            pout_reg <= pout_calc;
            pin_reg <= pin_calc;
        end
        else if (state_reg == cht_pkg::CHT_EFF)
        begin
            eff_reg <= eff_calc;
        end
    end

    // ************************************************************
    // Word store and read port
    // ************************************************************
    logic [15:0] wr_data;
    logic [15:0] mem_rd;
    logic req_d_reg;
    logic err_d_reg;

    always_comb
    begin
        case (idx_reg)
            cht_pkg::CHT_IX_TEMP: wr_data = temp_reg;
            cht_pkg::CHT_IX_POUT: wr_data = pout_reg;
            cht_pkg::CHT_IX_PIN: wr_data = pin_reg;
            cht_pkg::CHT_IX_EFF: wr_data = eff_reg;
            cht_pkg::CHT_IX_IOUT: wr_data = iout_reg;
            cht_pkg::CHT_IX_IIN: wr_data = iin_reg;
            cht_pkg::CHT_IX_VBAT: wr_data = vbat_reg;
            cht_pkg::CHT_IX_VFB: wr_data = vfb_reg;
            cht_pkg::CHT_IX_VPANEL: wr_data = vpanel_reg;
            default: wr_data = cht_pkg::CHT_RST_ZERO;
        endcase
    end

    cht_word_mem #(
        .WIDTH(cht_pkg::CHT_DATA_W),
        .DEPTH(cht_pkg::CHT_WORDS),
        .IDX_W(cht_pkg::CHT_IDX_W),
        .RESET_IMAGE(cht_pkg::CHT_RESET_IMAGE)
    ) u_mem (
        .clk(CLK),
        .nrst(NRST),
        .wr_en(state_reg == cht_pkg::CHT_WRITE),
        .wr_idx(idx_reg),
        .wr_data(wr_data),
        .rd_idx(RD_ADDR[4:1]),
        .rd_data(mem_rd)
    );

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            req_d_reg <= 1'b0;
            err_d_reg <= 1'b0;
        end
        else
        begin
            req_d_reg <= RD_REQ;
            err_d_reg <= RD_REQ & ~addr_ok(RD_ADDR);
        end
    end

    // The word stays put between reads, so the host may take both bytes at leisure.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            RD_DATA <= cht_pkg::CHT_RST_ZERO;
            RD_VALID <= 1'b0;
            RD_ERR <= 1'b0;
        end
        else
        begin
            RD_VALID <= req_d_reg;
            RD_ERR <= err_d_reg;
            if (req_d_reg)
            begin
                RD_DATA <= err_d_reg ? cht_pkg::CHT_RST_ZERO : mem_rd;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    sequence s_read_good;
        RD_REQ && addr_ok(RD_ADDR);
    endsequence

    sequence s_write_sweep;
        (state_reg == cht_pkg::CHT_WRITE) [*8] ##1 (state_reg == cht_pkg::CHT_WRITE)
            ##1 (state_reg == cht_pkg::CHT_IDLE);
    endsequence

    property p_read_latency;
        RD_REQ |-> ##2 RD_VALID;
    endproperty
    a_read_latency: assert property (p_read_latency) else $error("read answer late");

    property p_read_hold;
        !RD_VALID |-> $stable(RD_DATA);
    endproperty
    a_read_hold: assert property (p_read_hold) else $error("read word moved");

    property p_read_bad;
        (RD_REQ && !addr_ok(RD_ADDR)) |-> ##2 (RD_ERR && RD_DATA == 16'h0000);
    endproperty
    a_read_bad: assert property (p_read_bad) else $error("unmapped read not flagged");

    property p_read_good;
        s_read_good |-> ##2 (RD_VALID && !RD_ERR);
    endproperty
    a_read_good: assert property (p_read_good) else $error("mapped read flagged");

    property p_temp_unmeasured;
        !temp_seen_reg |-> (temp_reg == 16'h7FFF);
    endproperty
    a_temp_unmeasured: assert property (p_temp_unmeasured) else $error("temp not 7FFF");

    property p_disconnect;
        (MEAS.tbat_valid && MEAS.batt_disconnected) |=> (temp_reg == 16'h7777);
    endproperty
    a_disconnect: assert property (p_disconnect) else $error("disconnect code missing");

    property p_temp_range;
        (temp_seen_reg && temp_reg != 16'h7777)
            |-> ($signed(temp_reg) >= -16'sd450 && $signed(temp_reg) <= 16'sd650);
    endproperty
    a_temp_range: assert property (p_temp_range) else $error("temp out of range");

    property p_pout_invalid;
        (state_reg == cht_pkg::CHT_POWER && out_cfg_zero) |=> (pout_reg == 16'hFFFF);
    endproperty
    a_pout_invalid: assert property (p_pout_invalid) else $error("pout not FFFF");

    property p_eff_clamp;
        (eff_reg <= 16'd9999) || (eff_reg == 16'hFFFF);
    endproperty
    a_eff_clamp: assert property (p_eff_clamp) else $error("efficiency above 9999");

    property p_panel_dc;
        MEAS.dc_supply |=> (vpanel_reg == 16'h0000);
    endproperty
    a_panel_dc: assert property (p_panel_dc) else $error("panel word not zero on DC");

    property p_update_sweep;
        (state_reg == cht_pkg::CHT_EFF) |=> s_write_sweep;
    endproperty
    a_update_sweep: assert property (p_update_sweep) else $error("write sweep broken");

endmodule
`default_nettype wire

// File: verification/cht_host_model.sv
// Host side model: issues whole-word reads on the register read port.
// Assumes the bank answers each request with a single RD_VALID pulse.
`timescale 1ns/1ps
`default_nettype none
module cht_host_model (
    // Clock
    input wire logic CLK,
    // Read port
    output logic RD_REQ,
    output logic [7:0] RD_ADDR,
    input wire logic [15:0] RD_DATA,
    input wire logic RD_VALID,
    input wire logic RD_ERR
);
    initial
    begin
        RD_REQ = 1'b0;
        RD_ADDR = 8'hA5;
    end

    // One request returns all 16 bits, so both bytes come from one sample.
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic e,
        output int lat);
        lat = 0;
        @(posedge CLK);
        RD_REQ <= 1'b1;
        RD_ADDR <= a;
        @(posedge CLK);
        RD_REQ <= 1'b0;
        // A released address must not look like a held one.
        RD_ADDR <= ~a;
        for (int n = 1; n <= 4 && lat == 0; n++)
        begin
            @(posedge CLK);
            // Sampled values at this edge: the answer strobe launched one edge earlier.
            if (RD_VALID === 1'b1)
            begin
                lat = n;
                d = RD_DATA;
                e = RD_ERR;
            end
        end
    endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the telemetry word bank, read through a host model.
// Assumes answers come two cycles after the request edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk;
    logic nrst;
    cht_pkg::cht_meas_t meas;
    cht_pkg::cht_meas_t m;
    cht_pkg::cht_cfg_t cfg;
    logic rd_req;
    logic [7:0] rd_addr;
    logic [15:0] rd_data;
    logic rd_valid;
    logic rd_err;
    logic [15:0] rnd;
    logic [15:0] tcase [4] = '{16'hFF6A, 16'h02BC, 16'hFE00, 16'h0190};
    int n_errors;
    int checks;

    cht_telemetry_bank u_cht_telemetry_bank (.CLK(clk), .NRST(nrst), .MEAS(meas), .CFG(cfg),
        .RD_REQ(rd_req), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .RD_VALID(rd_valid),
        .RD_ERR(rd_err));
    cht_host_model u_cht_host_model (.CLK(clk), .RD_REQ(rd_req), .RD_ADDR(rd_addr),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_ERR(rd_err));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [15:0] rv();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        return {4'h0, rnd[11:0]};
    endfunction

    function automatic logic all_set(input int lo, input int hi);
        logic r;
        r = 1'b1;
        for (int f = lo; f <= hi; f++)
            r &= |cfg[143-16*f -: 16];
        return r;
    endfunction

    function automatic logic [15:0] pwr(input logic [15:0] i, input logic [15:0] v, input logic ok);
        logic [31:0] p;
        p = 32'(i) * 32'(v) / 32'h0000_03E8;
        if (!ok)
            return 16'hFFFF;
        return (p > 32'h0000_FFFE) ? 16'hFFFE : p[15:0];
    endfunction

    function automatic logic [15:0] exp_word(input int k);
        logic signed [15:0] t;
        logic [15:0] po;
        logic [15:0] pi;
        logic [31:0] ef;
        t = meas.tbat_c10;
        po = pwr(meas.iout_ma, meas.vbat_v100, all_set(1, 5));
        pi = pwr(meas.iin_ma, meas.dc_supply ? meas.vfb_v100 : meas.vpanel_v100,
            all_set(0, 0) && (!meas.dc_supply || all_set(6, 8)));
        ef = (pi == 16'h0000) ? 32'h0 : 32'(po) * 32'h2710 / 32'(pi);
        case (k)
            0: return meas.batt_disconnected ? 16'h7777 :
                (t < 16'shFE3E) ? 16'hFE3E : (t > 16'sh028A) ? 16'h028A : t;
            1: return po;
            2: return pi;
            3: return (po == 16'hFFFF || pi == 16'hFFFF) ? 16'hFFFF :
                (ef > 32'h270F) ? 16'h270F : ef[15:0];
            4: return meas.iout_ma;
            5: return meas.iin_ma;
            6: return meas.vbat_v100;
            7: return meas.vfb_v100;
            default: return meas.dc_supply ? 16'h0000 : meas.vpanel_v100;
        endcase
    endfunction

    function automatic cht_pkg::cht_meas_t with_v(input cht_pkg::cht_meas_t x, input logic v);
        {x.tbat_valid, x.iout_valid, x.iin_valid} = {3{v}};
        {x.vbat_valid, x.vfb_valid, x.vpanel_valid} = {3{v}};
        return x;
    endfunction

    task automatic close_out;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_cmp(input logic [7:0] a, input logic [15:0] exp, input logic err);
        logic [15:0] d;
        logic e;
        int lat;
        u_cht_host_model.rd(a, d, e, lat);
        if (lat == 0)
        begin
            n_errors++;
            close_out();
        end
        cmp($sformatf("latency at %h", a), 16'h0002, 16'(lat));
        cmp($sformatf("word at %h", a), exp, d);
        cmp($sformatf("error flag at %h", a), {15'h0000, err}, {15'h0000, e});
    endtask

    // The sweep after a sample needs about 13 cycles before the words are readable.
    task automatic apply(input cht_pkg::cht_meas_t x);
        @(posedge clk);
        meas <= with_v(x, 1'b1);
        @(posedge clk);
        meas <= with_v(x, 1'b0);
        repeat (16) @(posedge clk);
        for (int k = 0; k <= 8; k++)
            rd_cmp(8'(2 * k), exp_word(k), 1'b0);
    endtask

    initial
    begin
        n_errors = 0;
        checks = 0;
        rnd = 16'h0015;
        meas = '0;
        cfg = {9{16'h0101}};
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k <= 8; k++)
            rd_cmp(8'(2 * k), (k == 0) ? 16'h7FFF : (k == 8) ? 16'hFFFF : 16'h0000, 1'b0);
        rd_cmp(8'h01, 16'h0000, 1'b1);
        rd_cmp(8'h12, 16'h0000, 1'b1);
        for (int r = 0; r < 8; r++)
        begin
            m = meas;
            m.iout_ma = rv();
            m.iin_ma = rv();
            m.vbat_v100 = rv();
            m.vfb_v100 = rv();
            m.vpanel_v100 = rv();
            m.tbat_c10 = 16'(int'(rv() % 16'h044D) - 450);
            m.dc_supply = r[0];
            apply(m);
        end
        for (int c = 0; c < 4; c++)
        begin
            m = meas;
            m.tbat_c10 = tcase[c];
            m.batt_disconnected = (c == 3);
            // Full-scale current and voltage drive the power word into saturation.
            m.iout_ma = (c == 0) ? 16'hFFFF : m.iout_ma;
            m.vbat_v100 = (c == 0) ? 16'hFFFF : m.vbat_v100;
            apply(m);
        end
        for (int d = 0; d < 2; d++)
            for (int f = 0; f <= 8; f++)
            begin
                m = meas;
                m.dc_supply = d[0];
                m.batt_disconnected = 1'b0;
                @(posedge clk);
                cfg[143-16*f -: 16] <= 16'h0000;
                apply(m);
                @(posedge clk);
                cfg <= {9{16'h0101}};
            end
        close_out();
    end
endmodule
`default_nettype wire
